// >>> rtl/cssw_pkg.sv
// constants and types for the clock source, prescaler and sleep wake block
// assumes a 32-bit classic wishbone register port and a 125 MHz block clock
package cssw_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PRESC_CTRL = 8'h04;
    localparam logic [7:0] ADDR_SYS_CTRL2  = 8'h08;
    localparam logic [7:0] ADDR_CLK_CFG    = 8'h0C;
    localparam logic [7:0] ADDR_STATUS     = 8'h10;

    // sleep_wake_control fields
    localparam int SW_PULL_BIT = 3;
    localparam int SW_DIS_BIT  = 2;
    localparam int SW_SEL_HI   = 1;
    localparam int SW_SEL_LO   = 0;
    localparam logic [3:0] SLEEP_CTRL_RST = 4'h0;

    // prescaler_control fields
    localparam int PC_EXT_BIT    = 3;
    localparam int PC_CLR_BIT    = 2;
    localparam int PC_IRQSEL_BIT = 1;
    localparam int PC_DEB_BIT    = 0;

    // system_control_two and clock configuration fields
    localparam int SC2_OSC_STOP_BIT = 0;
    localparam int CFG_DIV_LSB      = 0;
    localparam int CFG_RCF_LSB      = 4;
    localparam int CFG_BASE_BIT     = 7;
    localparam int CFG_DEBOPT_BIT   = 8;
    localparam logic [2:0] DIV_MAX_SEL = 3'h4;

    // status fields
    localparam int ST_SRC_BIT  = 16;
    localparam int ST_ARM_BIT  = 17;
    localparam int ST_WAKE_BIT = 18;

    // prescaler chain: index i holds tap number 15 - i
    localparam int PRESC_W = 15;
    localparam logic [14:0] PRESC_POR      = 15'h4000;
    localparam logic [14:0] PRESC_CLR_KEEP = 15'h0001;
    localparam logic [14:0] PRESC_CLR_SET  = 15'h4000;
    localparam logic [14:0] PRESC_ZERO     = 15'h0000;
    localparam int TAP_CK1  = 14;
    localparam int TAP_CK4  = 11;
    localparam int TAP_CK7  = 8;
    localparam int TAP_CK8  = 7;
    localparam int TAP_CK11 = 4;
    localparam int TAP_CK14 = 1;

    // sleep timeouts in half periods of the low speed clock (3, 31, 255, 2047 for 1.5, 15.5, 127.5, 1023.5 periods)
    localparam logic [14:0] WAKE_HALF_0 = 15'h0003;
    localparam logic [14:0] WAKE_HALF_1 = 15'h001F;
    localparam logic [14:0] WAKE_HALF_2 = 15'h00FF;
    localparam logic [14:0] WAKE_HALF_3 = 15'h07FF;

    // wake reset length in system clock periods
    localparam logic [3:0] WAKE_RST_CYCLES = 4'hC;

    typedef enum logic [1:0] {
        SRC_RC  = 2'b01,
        SRC_EXT = 2'b10
    } cssw_src_t;

endpackage

// >>> rtl/cssw_top.sv
// clock source select, four stage divider, fifteen stage prescaler and sleep wake counter
// assumes rst_i is power-on reset, sys_reset_i carries the other system resets,
// rc_clk_i and ext_clk_i are slow asynchronous clock pins sampled by clk_i
// Summary of operation
// - wake counter runs only in sleep, resets
// - counter armed at sleep entry unless disabled
// - timeout 1.5/15.5/127.5/1023.5 low speed periods
// - bit 3 removes input 4 pull
// - wake counter reuses the prescaler chain
// - prescaler cleared at sleep entry when armed
// - rc after power-on, external when selected
// - glitch-free switch between clock sources
// - oscillator stop only after external selected
// - oscillator stopped during sleep
// - divider passes or divides by 2, 4, 8 or 16
// - rc frequency selectable, two bases
// - fifteen stage binary prescaler chain
// - power-on loads the chain with 4000 (tap 1 set)
// - chain clear: taps 14..2 cleared, tap 1 set
// - fast tick irq on tap 4 or 7
// - one hertz irq on tap 1 rise
// - debounce tap 8, or 11/14 by option
// - power-on reset raises no prescaler interrupt
// - external select cleared by power-on only
// - wake reset held twelve system clocks
`timescale 1ns/100ps
`default_nettype none

module cssw_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        sys_reset_i,
    input  wire logic        sleep_i,
    input  wire logic        rc_clk_i,
    input  wire logic        ext_clk_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             core_clock_o,
    output logic             peripheral_base_clock_o,
    output logic             sys_tick_o,
    output logic      [14:0] prescaler_tap_o,
    output logic             fast_tick_irq_o,
    output logic             one_hz_irq_o,
    output logic             debounce_clock_o,
    output logic             rc_osc_enable_o,
    output logic      [2:0]  rc_freq_sel_o,
    output logic             rc_base_50k_o,
    output logic             input4_pull_remove_o,
    output logic             wake_reset_o
);

    // mask of divider bits that must all be set for one system clock period
    function automatic logic [3:0] div_mask(input logic [2:0] sel);
        case (sel)
            3'h0:    div_mask = 4'h0;
            3'h1:    div_mask = 4'h1;
            3'h2:    div_mask = 4'h3;
            3'h3:    div_mask = 4'h7;
            default: div_mask = 4'hF;
        endcase
    endfunction

    // level of the divided clock for a given ratio
    function automatic logic div_level(input logic [2:0] sel, input logic [3:0] cnt,
                                       input logic src);
        case (sel)
            3'h0:    div_level = src;
            3'h1:    div_level = cnt[0];
            3'h2:    div_level = cnt[1];
            3'h3:    div_level = cnt[2];
            default: div_level = cnt[3];
        endcase
    endfunction

    // pin synchronisers: three stages, filtered level moves when stages two and three agree
    logic [1:0] pin_raw;
    logic [2:0] sync_q [2];
    logic [1:0] pin_f;
    assign pin_raw = {ext_clk_i, rc_clk_i};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                sync_q[gi] <= {sync_q[gi][1:0], pin_raw[gi]};
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pin_f[gi] <= 1'b0;
                end else if (sync_q[gi][2] == sync_q[gi][1]) begin
                    pin_f[gi] <= sync_q[gi][2];
                end
            end
        end
    endgenerate

    wire rc_f  = pin_f[0];
    wire ext_f = pin_f[1];

    // registers
    logic [3:0]  sleep_ctrl;
    logic        ext_sel;
    logic        irq_sel;
    logic        deb_sel;
    logic        osc_stop;
    logic [2:0]  div_sel;
    logic [2:0]  rc_freq;
    logic        rc_base;
    logic        deb_opt;

    // state
    cssw_pkg::cssw_src_t src_state;
    logic        src_prev;
    logic        rc_prev;
    logic [3:0]  div_cnt;
    logic [2:0]  div_act;
    logic [14:0] presc;
    logic        sleep_q;
    logic        scr_armed;
    logic [3:0]  wake_cnt;
    logic        clr_q;
    logic        fast_prev;
    logic        hz_prev;

    // wishbone decode
    wire        bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        bus_wr   = bus_req & wb_we_i;
    wire [7:0]  word_adr = {wb_adr_i[7:2], 2'b00};
    wire        hit_sw   = word_adr == cssw_pkg::ADDR_SLEEP_CTRL;
    wire        hit_pc   = word_adr == cssw_pkg::ADDR_PRESC_CTRL;
    wire        hit_sc2  = word_adr == cssw_pkg::ADDR_SYS_CTRL2;
    wire        hit_cfg  = word_adr == cssw_pkg::ADDR_CLK_CFG;
    wire        hit_st   = word_adr == cssw_pkg::ADDR_STATUS;
    wire        wr_lo    = bus_wr & wb_sel_i[0];
    wire        wr_hi    = bus_wr & wb_sel_i[1];
    wire        clr_wr   = wr_lo & hit_pc & wb_dat_i[cssw_pkg::PC_CLR_BIT];

    // sleep and reset conditions
    wire        wake_busy   = wake_cnt != 4'h0;
    wire        soft_rst    = sys_reset_i | wake_busy;
    wire        in_sleep    = sleep_i & ~wake_busy;
    wire        sleep_entry = sleep_i & ~sleep_q & ~wake_busy;
    wire        scr_enable  = ~sleep_ctrl[cssw_pkg::SW_DIS_BIT];
    wire [1:0]  wake_code   = {sleep_ctrl[cssw_pkg::SW_SEL_HI],
                               sleep_ctrl[cssw_pkg::SW_SEL_LO]};
    logic [14:0] wake_limit;
    always_comb begin
        unique case (wake_code)
            2'b00: wake_limit = cssw_pkg::WAKE_HALF_0;
            2'b01: wake_limit = cssw_pkg::WAKE_HALF_1;
            2'b10: wake_limit = cssw_pkg::WAKE_HALF_2;
            2'b11: wake_limit = cssw_pkg::WAKE_HALF_3;
        endcase
    end
    wire        scr_expire  = in_sleep & scr_armed & (presc == wake_limit);

    // clock source switch: changes only while both sources are low
    wire cssw_pkg::cssw_src_t src_want = ext_sel ? cssw_pkg::SRC_EXT : cssw_pkg::SRC_RC;
    wire        switch_ok = (src_state != src_want) & ~rc_f & ~ext_f;
    wire        src_lvl   = (src_state == cssw_pkg::SRC_EXT) ? ext_f : rc_f;
    wire        src_rise  = src_lvl & ~src_prev;
    wire        rc_edge   = rc_f ^ rc_prev;

    // four stage divider
    wire [3:0]  cur_mask  = div_mask(div_act);
    wire        sys_tick  = ~in_sleep & src_rise & ((div_cnt & cur_mask) == cur_mask);
    wire [2:0]  next_div  = (wb_dat_i[cssw_pkg::CFG_DIV_LSB +: 3] > cssw_pkg::DIV_MAX_SEL)
                            ? cssw_pkg::DIV_MAX_SEL : wb_dat_i[cssw_pkg::CFG_DIV_LSB +: 3];

    // prescaler step: system clock while awake, low speed rc half periods in sleep
    wire        presc_step = in_sleep ? (scr_armed & rc_edge) : sys_tick;
    logic [14:0] next_presc;
    always_comb begin
        if (sleep_entry && scr_enable) begin
            next_presc = cssw_pkg::PRESC_ZERO;
        end else if (clr_wr) begin
            next_presc = (presc & cssw_pkg::PRESC_CLR_KEEP) | cssw_pkg::PRESC_CLR_SET;
        end else if (presc_step) begin
            next_presc = presc + 15'h0001;
        end else begin
            next_presc = presc;
        end
    end

    // prescaler taps for interrupts and debouncer
    wire        fast_tap = irq_sel ? presc[cssw_pkg::TAP_CK7] : presc[cssw_pkg::TAP_CK4];
    wire        hz_tap   = presc[cssw_pkg::TAP_CK1];
    wire        deb_tap  = deb_sel ? (deb_opt ? presc[cssw_pkg::TAP_CK14]
                                              : presc[cssw_pkg::TAP_CK11])
                                   : presc[cssw_pkg::TAP_CK8];

    // read mux
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_sw) begin
            next_rdata[3:0] = sleep_ctrl;
        end else if (hit_pc) begin
            next_rdata[cssw_pkg::PC_EXT_BIT]    = ext_sel;
            next_rdata[cssw_pkg::PC_IRQSEL_BIT] = irq_sel;
            next_rdata[cssw_pkg::PC_DEB_BIT]    = deb_sel;
        end else if (hit_sc2) begin
            next_rdata[cssw_pkg::SC2_OSC_STOP_BIT] = osc_stop;
        end else if (hit_cfg) begin
            next_rdata[cssw_pkg::CFG_DIV_LSB +: 3] = div_sel;
            next_rdata[cssw_pkg::CFG_RCF_LSB +: 3] = rc_freq;
            next_rdata[cssw_pkg::CFG_BASE_BIT]     = rc_base;
            next_rdata[cssw_pkg::CFG_DEBOPT_BIT]   = deb_opt;
        end else if (hit_st) begin
            next_rdata[14:0]                    = presc;
            next_rdata[cssw_pkg::ST_SRC_BIT]    = src_state == cssw_pkg::SRC_EXT;
            next_rdata[cssw_pkg::ST_ARM_BIT]    = scr_armed;
            next_rdata[cssw_pkg::ST_WAKE_BIT]   = wake_busy;
        end
    end

    // bus answer: one wait state, ack for one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? next_rdata : 32'h0000_0000;
        end
    end

    // registers cleared by power-on only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_ctrl <= cssw_pkg::SLEEP_CTRL_RST;
            ext_sel    <= 1'b0;
            div_sel    <= 3'h0;
            rc_freq    <= 3'h0;
            rc_base    <= 1'b0;
            deb_opt    <= 1'b0;
        end else begin
            if (wr_lo && hit_sw) begin
                sleep_ctrl <= wb_dat_i[3:0];
            end
            if (wr_lo && hit_pc) begin
                ext_sel <= wb_dat_i[cssw_pkg::PC_EXT_BIT];
            end
            if (wr_lo && hit_cfg) begin
                div_sel <= next_div;
                rc_freq <= wb_dat_i[cssw_pkg::CFG_RCF_LSB +: 3];
                rc_base <= wb_dat_i[cssw_pkg::CFG_BASE_BIT];
            end
            if (wr_hi && hit_cfg) begin
                deb_opt <= wb_dat_i[cssw_pkg::CFG_DEBOPT_BIT];
            end
        end
    end

    // registers cleared by any system reset
    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst) begin
            irq_sel  <= 1'b0;
            deb_sel  <= 1'b0;
            osc_stop <= 1'b0;
        end else begin
            if (wr_lo && hit_pc) begin
                irq_sel <= wb_dat_i[cssw_pkg::PC_IRQSEL_BIT];
                deb_sel <= wb_dat_i[cssw_pkg::PC_DEB_BIT];
            end
            if (wr_lo && hit_sc2) begin
                osc_stop <= wb_dat_i[cssw_pkg::SC2_OSC_STOP_BIT] & ext_sel;
            end
        end
    end

    // clock source and divider
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_state <= cssw_pkg::SRC_RC;
            src_prev  <= 1'b0;
            rc_prev   <= 1'b0;
            div_cnt   <= 4'h0;
            div_act   <= 3'h0;
        end else begin
            if (switch_ok) begin
                src_state <= src_want;
            end
            src_prev <= src_lvl;
            rc_prev  <= rc_f;
            if (sys_tick) begin
                div_cnt <= 4'h0;
                div_act <= div_sel;
            end else if (src_rise && !in_sleep) begin
                div_cnt <= div_cnt + 4'h1;
            end
        end
    end

    // prescaler chain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc <= cssw_pkg::PRESC_POR;
            clr_q <= 1'b0;
        end else begin
            presc <= next_presc;
            clr_q <= clr_wr;
        end
    end

    // sleep wake counter and wake reset stretch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_q   <= 1'b0;
            scr_armed <= 1'b0;
            wake_cnt  <= 4'h0;
        end else begin
            sleep_q <= sleep_i;
            if (sleep_entry) begin
                scr_armed <= scr_enable;
            end else if (!sleep_i || scr_expire) begin
                scr_armed <= 1'b0;
            end
            if (scr_expire) begin
                wake_cnt <= cssw_pkg::WAKE_RST_CYCLES;
            end else if (wake_busy && sys_tick) begin
                wake_cnt <= wake_cnt - 4'h1;
            end
        end
    end

    // interrupt edges; previous taps start at the power-on chain value so reset is silent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_prev       <= cssw_pkg::PRESC_POR[cssw_pkg::TAP_CK4];
            hz_prev         <= cssw_pkg::PRESC_POR[cssw_pkg::TAP_CK1];
            fast_tick_irq_o <= 1'b0;
            one_hz_irq_o    <= 1'b0;
        end else begin
            fast_prev       <= fast_tap;
            hz_prev         <= hz_tap;
            fast_tick_irq_o <= fast_tap & ~fast_prev & ~clr_q;
            one_hz_irq_o    <= hz_tap & ~hz_prev & ~clr_q;
        end
    end

    // registered clock and level outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_clock_o            <= 1'b0;
            peripheral_base_clock_o <= 1'b0;
            sys_tick_o              <= 1'b0;
            prescaler_tap_o         <= cssw_pkg::PRESC_POR;
            debounce_clock_o        <= 1'b0;
        end else begin
            core_clock_o            <= src_lvl;
            peripheral_base_clock_o <= div_level(div_act, div_cnt, src_lvl);
            sys_tick_o              <= sys_tick;
            prescaler_tap_o         <= presc;
            debounce_clock_o        <= deb_tap;
        end
    end

    assign rc_osc_enable_o      = ~osc_stop & ~in_sleep;
    assign rc_freq_sel_o        = rc_freq;
    assign rc_base_50k_o        = rc_base;
    assign input4_pull_remove_o = sleep_ctrl[cssw_pkg::SW_PULL_BIT];
    assign wake_reset_o         = wake_busy;

endmodule // cssw_top

`default_nettype wire

// >>> sim/cssw_top_sva.sv
// concurrent checks on the ports of the clock source and prescaler block
// assumes clk_i is the only clock and rst_i a synchronous power-on reset
`timescale 1ns/100ps
`default_nettype none
module cssw_top_sva (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        sleep_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        core_clock_o,
    input wire logic        sys_tick_o,
    input wire logic        peripheral_base_clock_o,
    input wire logic [14:0] prescaler_tap_o,
    input wire logic        fast_tick_irq_o,
    input wire logic        one_hz_irq_o,
    input wire logic        rc_osc_enable_o,
    input wire logic        wake_reset_o
);
    logic [4:0] wake_ticks;
    // system clock periods seen while the wake reset is held
    always_ff @(posedge clk_i) begin
        if (rst_i || !wake_reset_o) begin
            wake_ticks <= 5'h00;
        end else if (sys_tick_o) begin
            wake_ticks <= wake_ticks + 5'h01;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in the next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack stayed high");
    a_reset_quiet: assert property ($fell(rst_i) |->
        (!one_hz_irq_o && !fast_tick_irq_o) [*3])
        else $error("interrupt right after reset");
    a_chain_start: assert property ($fell(rst_i) |-> prescaler_tap_o == 15'h4000)
        else $error("prescaler chain wrong after power-on");
    a_hz_edge: assert property (one_hz_irq_o |-> prescaler_tap_o == 15'h4000)
        else $error("one hertz irq without a tap 1 rise");
    a_fast_edge: assert property (fast_tick_irq_o |->
        prescaler_tap_o[8:0] == 9'h100 || prescaler_tap_o[11:0] == 12'h800)
        else $error("fast irq without a tap 4 or tap 7 rise");
    a_wake_length: assert property ($fell(wake_reset_o) |-> wake_ticks inside {5'h0B, 5'h0C})
        else $error("wake reset not held twelve system clocks");
    a_wake_in_sleep: assert property ($rose(wake_reset_o) |-> $past(sleep_i))
        else $error("wake reset outside sleep");
    a_sleep_osc_off: assert property (sleep_i && $past(sleep_i) && !wake_reset_o |-> !rc_osc_enable_o)
        else $error("oscillator running in sleep");
    a_no_runt: assert property ($rose(core_clock_o) |=> core_clock_o [*3])
        else $error("runt pulse on core clock");
    a_div_level: assert property (sys_tick_o |-> peripheral_base_clock_o)
        else $error("system clock low at its tick");
    c_fast_irq: cover property (fast_tick_irq_o);
    c_wake: cover property ($rose(wake_reset_o));
    c_bus: cover property (wb_ack_o);
endmodule // cssw_top_sva
bind cssw_top cssw_top_sva sva_u (
    .clk_i(clk_i), .rst_i(rst_i), .sleep_i(sleep_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .core_clock_o(core_clock_o),
    .sys_tick_o(sys_tick_o), .prescaler_tap_o(prescaler_tap_o),
    .peripheral_base_clock_o(peripheral_base_clock_o),
    .fast_tick_irq_o(fast_tick_irq_o), .one_hz_irq_o(one_hz_irq_o),
    .rc_osc_enable_o(rc_osc_enable_o), .wake_reset_o(wake_reset_o)
);
`default_nettype wire

// >>> sim/cssw_env_model.sv
// oscillator pins and cpu sleep handshake around the clock block
// assumes one bench clock; both pins toggle on fixed counts of it
`timescale 1ns/100ps
`default_nettype none
module cssw_env_model #(
    parameter int RC_HALF  = 4,
    parameter int EXT_HALF = 6
) (
    input  wire logic clk_i,
    input  wire logic sleep_req_i,
    input  wire logic wake_reset_i,
    output var logic  rc_clk_o,
    output var logic  ext_clk_o,
    output var logic  sleep_o
);
    int   rc_cnt;
    int   ext_cnt;
    logic req_q;
    initial begin
        rc_cnt = 0;
        ext_cnt = 0;
        req_q = 1'b0;
        rc_clk_o = 1'b0;
        ext_clk_o = 1'b0;
        sleep_o = 1'b0;
    end
    always @(posedge clk_i) begin
        // low speed oscillator keeps running so sleep timing has edges
        rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
        if (rc_cnt == RC_HALF - 1) rc_clk_o <= ~rc_clk_o;
        // full swing square wave on the external pin
        ext_cnt <= (ext_cnt == EXT_HALF - 1) ? 0 : ext_cnt + 1;
        if (ext_cnt == EXT_HALF - 1) ext_clk_o <= ~ext_clk_o;
        // cpu leaves sleep as soon as the wake reset arrives
        req_q <= sleep_req_i;
        if (wake_reset_i || !sleep_req_i) sleep_o <= 1'b0;
        else if (!req_q) sleep_o <= 1'b1;
    end
endmodule // cssw_env_model
`default_nettype wire

// >>> sim/cssw_top_test.sv
// self-checking bench: registers, divider, prescaler irqs, debounce tap, sleep wake
// assumes the pin model drives the oscillator pins and the sleep level
`timescale 1ns/100ps
`default_nettype none
module cssw_top_test;
    localparam int H = 4;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        sys_reset_i = 1'b0;
    logic        sleep_req = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, q;
    logic [14:0] prescaler_tap_o;
    logic        wb_ack_o, core_clock_o, sys_tick_o, fast_tick_irq_o, one_hz_irq_o;
    logic        debounce_clock_o, rc_osc_enable_o, input4_pull_remove_o, wake_reset_o;
    logic        sleep_i, rc_clk_i, ext_clk_i;
    wire  [3:0]  rcf;
    int          mismatches = 0;
    int          total_checks = 0;
    int          c, n;
    always #4 clk_i = ~clk_i;
    cssw_env_model #(.RC_HALF(H), .EXT_HALF(6)) env_u (.clk_i(clk_i), .sleep_req_i(sleep_req),
        .wake_reset_i(wake_reset_o), .rc_clk_o(rc_clk_i), .ext_clk_o(ext_clk_i), .sleep_o(sleep_i));
    cssw_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .sys_reset_i(sys_reset_i), .sleep_i(sleep_i),
        .rc_clk_i(rc_clk_i), .ext_clk_i(ext_clk_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_clock_o(core_clock_o),
        .peripheral_base_clock_o(), .sys_tick_o(sys_tick_o), .prescaler_tap_o(prescaler_tap_o),
        .fast_tick_irq_o(fast_tick_irq_o), .one_hz_irq_o(one_hz_irq_o),
        .debounce_clock_o(debounce_clock_o), .rc_osc_enable_o(rc_osc_enable_o),
        .rc_freq_sel_o(rcf[2:0]), .rc_base_50k_o(rcf[3]),
        .input4_pull_remove_o(input4_pull_remove_o), .wake_reset_o(wake_reset_o));
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task timed_out;
        mismatches++;
        end_of_test();
    endtask
    // one classic cycle, entered just after a rising edge; read data lands in q
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (wb_ack_o !== 1'b1) timed_out();
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // 0 tick, 1 fast irq, 2 wake high, 3 wake low; c gets the cycles waited
    task wait_on(input int w, input int lim, output int cnt);
        logic hit;
        cnt = 0;
        hit = 1'b0;
        while (!hit) begin
            @(negedge clk_i);
            cnt++;
            hit = (w == 0) ? sys_tick_o === 1'b1 : (w == 1) ? fast_tick_irq_o === 1'b1 :
                  (w == 2) ? wake_reset_o === 1'b1 : wake_reset_o === 1'b0;
            if (cnt >= lim) timed_out();
        end
        @(posedge clk_i);
    endtask
    task t_regs;
        wb(1'b0, 8'h00, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_0000);
        wb(1'b0, 8'h04, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_0000);
        wb(1'b0, 8'h20, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_0000);
        wb(1'b1, 8'h00, 32'h0000_000F, 4'hF);
        wb(1'b0, 8'h00, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_000F);
        chk(input4_pull_remove_o, 1'h1);
        wb(1'b1, 8'h0C, 32'h0000_00C0, 4'hF);
        chk(rcf, 4'hC);
        wb(1'b1, 8'h00, 32'h0000_0000, 4'hF);
    endtask
    // clear, then tap 7 irq spacing, then tap 4 irq, switching where no false edge can occur
    task t_clear_irq;
        wb(1'b1, 8'h04, 32'h0000_0004, 4'hF);
        wb(1'b1, 8'h04, 32'h0000_0002, 4'hF);
        wb(1'b0, 8'h10, 32'h0000_0000, 4'hF);
        chk(q[14:2], 13'h1000);
        wb(1'b0, 8'h04, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_0002);
        wait_on(1, 3000, c);
        n = 0;
        c = 0;
        do begin
            @(negedge clk_i);
            if (sys_tick_o === 1'b1) n++;
            c++;
        end while (fast_tick_irq_o !== 1'b1 && c < 6000);
        @(posedge clk_i);
        chk(n, 512);
        wb(1'b1, 8'h04, 32'h0000_0000, 4'hF);
        wait_on(1, 20000, c);
        chk(prescaler_tap_o[11:0], 12'h800);
    endtask
    task t_div;
        for (int s = 0; s < 5; s++) begin
            wb(1'b1, 8'h0C, s, 4'hF);
            wait_on(0, 600, c);
            wait_on(0, 600, c);
            wait_on(0, 600, c);
            chk(c, (2 * H) << s);
        end
        wb(1'b1, 8'h0C, 32'h0000_0000, 4'hF);
        wait_on(0, 600, c);
    endtask
    task t_deb;
        int idx[3];
        idx = '{7, 4, 1};
        for (int m = 0; m < 3; m++) begin
            wb(1'b1, 8'h0C, (m == 2) ? 32'h0000_0100 : 32'h0000_0000, 4'h3);
            wb(1'b1, 8'h04, (m > 0) ? 32'h0000_0001 : 32'h0000_0000, 4'hF);
            wait_on(0, 600, c);
            repeat (3) @(posedge clk_i);
            chk(debounce_clock_o, prescaler_tap_o[idx[m]]);
        end
    endtask
    task t_ext;
        wb(1'b1, 8'h08, 32'h0000_0001, 4'hF);
        wb(1'b0, 8'h08, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_0000);
        wb(1'b1, 8'h04, 32'h0000_0008, 4'hF);
        repeat (40) @(posedge clk_i);
        wb(1'b0, 8'h10, 32'h0000_0000, 4'hF);
        chk(q[16], 1'h1);
        wb(1'b1, 8'h08, 32'h0000_0001, 4'hF);
        wb(1'b0, 8'h08, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_0001);
        chk(rc_osc_enable_o, 1'h0);
        sys_reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_reset_i <= 1'b0;
        @(posedge clk_i);
        chk(rc_osc_enable_o, 1'h1);
        wb(1'b0, 8'h04, 32'h0000_0000, 4'hF);
        chk(q, 32'h0000_0008);
        wb(1'b1, 8'h04, 32'h0000_0000, 4'hF);
        repeat (40) @(posedge clk_i);
        wb(1'b0, 8'h10, 32'h0000_0000, 4'hF);
        chk(q[16], 1'h0);
    endtask
    task t_sleep;
        int half_cnt[4];
        half_cnt = '{3, 31, 255, 2047};
        for (int s = 0; s < 4; s++) begin
            wb(1'b1, 8'h00, s, 4'hF);
            sleep_req <= 1'b1;
            wait_on(2, 10000, c);
            chk(c >= (half_cnt[s] - 1) * H && c <= half_cnt[s] * H + 10, 1'h1);
            sleep_req <= 1'b0;
            wait_on(3, 400, c);
        end
        wb(1'b1, 8'h00, 32'h0000_0004, 4'hF);
        sleep_req <= 1'b1;
        repeat (600) @(posedge clk_i);
        chk(wake_reset_o, 1'h0);
        chk(rc_osc_enable_o, 1'h0);
        sleep_req <= 1'b0;
        @(posedge clk_i);
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_clear_irq();
        t_div();
        t_deb();
        t_ext();
        t_sleep();
        end_of_test();
    end
endmodule // cssw_top_test
`default_nettype wire
